// ### verilog/frc_fault_response.sv
// fault response registers and shutdown / restart sequencer
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE_01 - overcurrent action 00: no shutdown, but every event cuts the PWM pulse
// RULE_02 - action 01: after allowed cycles shut down, then soft start
// RULE_03 - action 10: cut pulses for allowed cycles, shut down, await power-on request
// RULE_04 - action 11: after allowed cycles disable PWM until fault flag cleared
// RULE_05 - cycle-count field 00/01/10/11 allows 1/2/4/8 switching cycles
// RULE_06 - fast overvoltage field: ignore, restart, wait power-on, or latch off
// RULE_07 - open-loop field uses the same four actions
// RULE_08 - supply bit 6 saves first fault identifier to EEPROM on shutdown
// RULE_09 - supply field [5:3] sets retry wait, 588 ms per step
// RULE_10 - supply bit 2 requests EEPROM configuration reload on fault response
// RULE_11 - supply bit 0 makes the 3.3 V overvoltage fault ignored
// RULE_12 - supply bit 1 picks 2.56 us or 660 us fault debounce
// RULE_13 - reserved bits read zero and ignore writes
module frc_fault_response
    import frc_pkg::*;
#(
    parameter int RETRY_STEP_CYC = FRC_RETRY_STEP_CYC,
    parameter int DEB_LONG_CYC = FRC_DEB_LONG_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire frc_reg_req_t reg_req,
    output logic [7:0] reg_rdata_q,
    output logic reg_rvalid_q,
    input wire frc_fault_in_t faults,
    input wire logic sw_cycle,
    input wire logic power_on_request,
    input wire logic flag_clear,
    input wire logic soft_start_done,
    output logic pwm_enable_q,
    output logic pwm_terminate_q,
    output logic soft_start_req_q,
    output logic eeprom_save_q,
    output logic eeprom_reload_q,
    output frc_flag_id_t first_flag_id_q
);

    logic [7:0] ocp_reg_q;
    logic [7:0] ovp_reg_q;
    logic [7:0] olp_reg_q;
    logic [7:0] vdd_reg_q;
    frc_state_t state_q;
    frc_state_t state_d;
    logic [3:0] ncnt_q;
    logic [31:0] retry_cnt_q;
    logic vdd_filt;
    logic vdd_filt_q;
    logic vdd_rise;
    logic running;
    logic ocp_due;
    logic evt;
    frc_action_t act;
    frc_flag_id_t evt_id;
    frc_action_t ocp_act;
    frc_action_t ovp_act;
    frc_action_t olp_act;
    logic [3:0] ncyc;
    logic [2:0] retry_field;

    assign ocp_act = frc_action_t'(ocp_reg_q[FRC_ACT_LSB +: 2]);
    assign ovp_act = frc_action_t'(ovp_reg_q[FRC_ACT_LSB +: 2]);
    assign olp_act = frc_action_t'(olp_reg_q[FRC_ACT_LSB +: 2]);
    assign ncyc = 4'h1 << ocp_reg_q[FRC_NCYC_LSB +: 2]; // RULE_05
    assign retry_field = vdd_reg_q[FRC_RETRY_LSB +: 3];

    // =========================================================
    // register access
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ocp_reg_q <= FRC_RST_OCP;
            ovp_reg_q <= FRC_RST_OVP;
            olp_reg_q <= FRC_RST_OLP;
            vdd_reg_q <= FRC_RST_VDD;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                FRC_ADDR_OCP: ocp_reg_q <= reg_req.wdata & FRC_WMASK_OCP; // RULE_13
                FRC_ADDR_OVP: ovp_reg_q <= reg_req.wdata & FRC_WMASK_OVP; // RULE_13
                FRC_ADDR_OLP: olp_reg_q <= reg_req.wdata & FRC_WMASK_OLP; // RULE_13
                FRC_ADDR_VDD: vdd_reg_q <= reg_req.wdata & FRC_WMASK_VDD; // RULE_13
                default: ;
            endcase
        end
    end

    // unmapped reads answer zero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_req.rd;
            case (reg_req.addr)
                FRC_ADDR_OCP: reg_rdata_q <= ocp_reg_q;
                FRC_ADDR_OVP: reg_rdata_q <= ovp_reg_q;
                FRC_ADDR_OLP: reg_rdata_q <= olp_reg_q;
                FRC_ADDR_VDD: reg_rdata_q <= vdd_reg_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // =========================================================
    // supply overvoltage detection
    frc_debounce #(
        .SHORT_CYC(FRC_DEB_SHORT_CYC),
        .LONG_CYC(DEB_LONG_CYC)
    ) u_deb (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .raw(faults.vdd_ov),
        .short_sel(vdd_reg_q[FRC_DEB_BIT]), // RULE_12
        .filt_q(vdd_filt)
    );

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            vdd_filt_q <= 1'b0;
        end else begin
            vdd_filt_q <= vdd_filt;
        end
    end
    assign vdd_rise = vdd_filt && !vdd_filt_q;

    // =========================================================
    // fault arbitration: fast overvoltage first, overcurrent last
    assign running = (state_q == FRC_RUN) || (state_q == FRC_COUNT) ||
                     (state_q == FRC_SSTART);
    assign ocp_due = (state_q == FRC_COUNT) && sw_cycle && (ncnt_q == 4'h1);

    always_comb begin
        evt = 1'b0;
        act = FRC_ACT_IGNORE;
        evt_id = FRC_ID_NONE;
        if (running) begin
            if (faults.ovp && ovp_act != FRC_ACT_IGNORE) begin // RULE_06
                evt = 1'b1;
                act = ovp_act;
                evt_id = FRC_ID_OVP;
            end else if (faults.olp && olp_act != FRC_ACT_IGNORE) begin // RULE_07
                evt = 1'b1;
                act = olp_act;
                evt_id = FRC_ID_OLP;
            end else if (vdd_rise && !vdd_reg_q[FRC_IGN_BIT]) begin // RULE_11
                evt = 1'b1;
                act = FRC_ACT_RESTART;
                evt_id = FRC_ID_VDD;
            end else if (ocp_due) begin // RULE_02
                evt = 1'b1;
                act = ocp_act;
                evt_id = FRC_ID_OCP;
            end
        end
    end

    // =========================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            FRC_RUN, FRC_COUNT, FRC_SSTART: begin
                if (evt) begin
                    case (act)
                        // retry wait lasts at least one cycle, so even a zero
                        // wait drops the PWM before the soft start
                        FRC_ACT_RESTART: state_d = FRC_RETRY; // RULE_02
                        FRC_ACT_WAITPON: state_d = FRC_WAIT_PON; // RULE_03
                        FRC_ACT_LATCH: state_d = FRC_LATCHED; // RULE_04
                        default: state_d = state_q;
                    endcase
                end else if (state_q == FRC_RUN && faults.ocp &&
                             ocp_act != FRC_ACT_IGNORE) begin
                    state_d = FRC_COUNT; // RULE_01
                end else if (state_q == FRC_SSTART && soft_start_done) begin
                    state_d = FRC_RUN;
                end
            end
            FRC_RETRY: begin
                if (retry_cnt_q <= 32'h1) begin
                    state_d = FRC_SSTART; // RULE_09
                end
            end
            FRC_WAIT_PON: begin
                if (power_on_request) begin
                    state_d = FRC_SSTART; // RULE_03
                end
            end
            FRC_LATCHED: begin
                if (flag_clear) begin
                    state_d = FRC_RUN; // RULE_04
                end
            end
            default: state_d = FRC_RUN;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FRC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // allowed switching cycles after an overcurrent detection
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ncnt_q <= 4'h0;
        end else if (state_q == FRC_RUN && state_d == FRC_COUNT) begin
            ncnt_q <= ncyc; // RULE_05
        end else if (state_q == FRC_COUNT && sw_cycle && ncnt_q != 4'h0) begin
            ncnt_q <= ncnt_q - 4'h1;
        end
    end

    // retry wait; the product stays below 2^31 for a 3-bit field
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            retry_cnt_q <= 32'h0;
        end else if (state_q != FRC_RETRY && state_d == FRC_RETRY) begin
            retry_cnt_q <= 32'(retry_field) * 32'(RETRY_STEP_CYC); // RULE_09
        end else if (state_q == FRC_RETRY && retry_cnt_q != 32'h0) begin
            retry_cnt_q <= retry_cnt_q - 32'h1;
        end
    end

    // =========================================================
    // outputs
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_terminate_q <= 1'b0;
            pwm_enable_q <= 1'b0;
            soft_start_req_q <= 1'b0;
        end else begin
            // pulse cut happens in every mode, ignore included
            pwm_terminate_q <= faults.ocp; // RULE_01
            pwm_enable_q <= (state_d == FRC_RUN) || (state_d == FRC_COUNT) ||
                            (state_d == FRC_SSTART);
            soft_start_req_q <= (state_d == FRC_SSTART);
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            eeprom_save_q <= 1'b0;
            eeprom_reload_q <= 1'b0;
        end else begin
            eeprom_save_q <= evt && vdd_reg_q[FRC_SAVE_BIT]; // RULE_08
            eeprom_reload_q <= evt && vdd_reg_q[FRC_RELOAD_BIT]; // RULE_10
        end
    end

    // first flag holds until cleared; a fault in the clear cycle cancels the clear, so the held flag stays
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            first_flag_id_q <= FRC_ID_NONE;
        end else if (evt && first_flag_id_q == FRC_ID_NONE) begin
            first_flag_id_q <= evt_id; // RULE_08
        end else if (flag_clear && !evt) begin
            first_flag_id_q <= FRC_ID_NONE;
        end
    end

    // =========================================================
    // checks
    property p_ocp_cut;
        @(posedge clk_sys) disable iff (sys_rst)
        faults.ocp |=> pwm_terminate_q;
    endproperty
    a_ocp_cut: assert property (p_ocp_cut) // RULE_01
        else $error("overcurrent pulse not cut");

    property p_ocp_ignore;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == FRC_RUN && ocp_act == FRC_ACT_IGNORE && !evt
            |=> state_q == FRC_RUN && pwm_enable_q;
    endproperty
    a_ocp_ignore: assert property (p_ocp_ignore) // RULE_01
        else $error("ignored overcurrent left run state");

    property p_restart;
        @(posedge clk_sys) disable iff (sys_rst)
        evt && act == FRC_ACT_RESTART
            |=> state_q == FRC_RETRY && !pwm_enable_q;
    endproperty
    a_restart: assert property (p_restart) // RULE_02
        else $error("restart action did not enter retry wait");

    property p_waitpon;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == FRC_WAIT_PON && !power_on_request
            |=> state_q == FRC_WAIT_PON && !pwm_enable_q;
    endproperty
    a_waitpon: assert property (p_waitpon) // RULE_03
        else $error("power-on wait left without request");

    property p_waitpon_enter;
        @(posedge clk_sys) disable iff (sys_rst)
        evt && act == FRC_ACT_WAITPON |=> state_q == FRC_WAIT_PON && !pwm_enable_q;
    endproperty
    a_waitpon_enter: assert property (p_waitpon_enter) // RULE_03
        else $error("power-on wait not entered");

    property p_latched;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == FRC_LATCHED && !flag_clear
            |=> state_q == FRC_LATCHED && !pwm_enable_q;
    endproperty
    a_latched: assert property (p_latched) // RULE_04
        else $error("latched fault released without clear");

    property p_ncyc;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == FRC_RUN && state_d == FRC_COUNT |=> ncnt_q == $past(ncyc);
    endproperty
    a_ncyc: assert property (p_ncyc) // RULE_05
        else $error("allowed cycle count wrong");

    property p_ovp;
        @(posedge clk_sys) disable iff (sys_rst)
        running && faults.ovp && ovp_act != FRC_ACT_IGNORE |=> !pwm_enable_q
            || state_q == FRC_SSTART;
    endproperty
    a_ovp: assert property (p_ovp) // RULE_06
        else $error("fast overvoltage not acted upon");

    property p_save_reload;
        @(posedge clk_sys) disable iff (sys_rst)
        evt |=> eeprom_save_q == $past(vdd_reg_q[FRC_SAVE_BIT]) &&
                eeprom_reload_q == $past(vdd_reg_q[FRC_RELOAD_BIT]);
    endproperty
    a_save_reload: assert property (p_save_reload) // RULE_08
        else $error("eeprom request does not follow enables");

    property p_retry_end;
        @(posedge clk_sys) disable iff (sys_rst)
        state_q == FRC_RETRY && retry_cnt_q == 32'h1 |=> state_q == FRC_SSTART;
    endproperty
    a_retry_end: assert property (p_retry_end) // RULE_09
        else $error("retry wait overran");

    property p_reserved;
        @(posedge clk_sys) disable iff (sys_rst)
        reg_req.rd && reg_req.addr == FRC_ADDR_OCP |=> reg_rdata_q[3:0] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) // RULE_13
        else $error("reserved bits read nonzero");

    c_retry: cover property (@(posedge clk_sys) state_q == FRC_RETRY);
    c_waitpon: cover property (@(posedge clk_sys) state_q == FRC_WAIT_PON);
    c_latched: cover property (@(posedge clk_sys) state_q == FRC_LATCHED);
    c_count: cover property (@(posedge clk_sys) ocp_due);

endmodule

`default_nettype wire

// ### verilog/frc_pkg.sv
// constants, types and register map of the fault response configuration
package frc_pkg;

    // =========================================================
    // register map
    localparam logic [15:0] FRC_ADDR_OCP = 16'hFE00;
    localparam logic [15:0] FRC_ADDR_OVP = 16'hFE01;
    localparam logic [15:0] FRC_ADDR_OLP = 16'hFE02;
    localparam logic [15:0] FRC_ADDR_VDD = 16'hFE03;

    localparam logic [7:0] FRC_RST_OCP = 8'h00;
    localparam logic [7:0] FRC_RST_OVP = 8'h00;
    localparam logic [7:0] FRC_RST_OLP = 8'h00;
    localparam logic [7:0] FRC_RST_VDD = 8'h00;

    // writable bits; everything else is reserved and reads zero
    localparam logic [7:0] FRC_WMASK_OCP = 8'hF0;
    localparam logic [7:0] FRC_WMASK_OVP = 8'hC0;
    localparam logic [7:0] FRC_WMASK_OLP = 8'hC0;
    localparam logic [7:0] FRC_WMASK_VDD = 8'h7F;

    // =========================================================
    // field positions
    localparam int FRC_ACT_LSB = 6;
    localparam int FRC_NCYC_LSB = 4;
    localparam int FRC_SAVE_BIT = 6;
    localparam int FRC_RETRY_LSB = 3;
    localparam int FRC_RELOAD_BIT = 2;
    localparam int FRC_DEB_BIT = 1;
    localparam int FRC_IGN_BIT = 0;

    // =========================================================
    // timing
    localparam int FRC_CLK_MHZ = 250;
    localparam int FRC_RETRY_STEP_MS = 588;
    localparam int FRC_RETRY_STEP_CYC = FRC_RETRY_STEP_MS * FRC_CLK_MHZ * 1000;
    localparam int FRC_DEB_SHORT_NS = 2560;
    localparam int FRC_DEB_SHORT_CYC =
        (FRC_DEB_SHORT_NS * FRC_CLK_MHZ + 999) / 1000;
    localparam int FRC_DEB_LONG_US = 660;
    localparam int FRC_DEB_LONG_CYC = FRC_DEB_LONG_US * FRC_CLK_MHZ;

    // =========================================================
    // types
    typedef enum logic [2:0] {
        FRC_RUN      = 3'h0,
        FRC_COUNT    = 3'h1,
        FRC_RETRY    = 3'h3,
        FRC_SSTART   = 3'h2,
        FRC_WAIT_PON = 3'h6,
        FRC_LATCHED  = 3'h7
    } frc_state_t;

    typedef enum logic [1:0] {
        FRC_ACT_IGNORE  = 2'h0,
        FRC_ACT_RESTART = 2'h1,
        FRC_ACT_WAITPON = 2'h2,
        FRC_ACT_LATCH   = 2'h3
    } frc_action_t;

    typedef enum logic [2:0] {
        FRC_ID_NONE = 3'h0,
        FRC_ID_OCP  = 3'h1,
        FRC_ID_OVP  = 3'h2,
        FRC_ID_OLP  = 3'h3,
        FRC_ID_VDD  = 3'h4
    } frc_flag_id_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } frc_reg_req_t;

    typedef struct packed {
        logic ocp;
        logic ovp;
        logic olp;
        logic vdd_ov;
    } frc_fault_in_t;

endpackage

// ### verilog/frc_debounce.sv
// persistence filter for the supply overvoltage detector
`timescale 1ns/1ps
`default_nettype none

module frc_debounce
    import frc_pkg::*;
#(
    parameter int SHORT_CYC = FRC_DEB_SHORT_CYC,
    parameter int LONG_CYC = FRC_DEB_LONG_CYC
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic raw,
    input wire logic short_sel,
    output logic filt_q
);

    // either window may be the longer one, so size for the larger limit
    localparam int MAX_CYC = (SHORT_CYC > LONG_CYC) ? SHORT_CYC : LONG_CYC;
    localparam int CW = $clog2(MAX_CYC + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] lim;

    assign lim = short_sel ? CW'(SHORT_CYC) : CW'(LONG_CYC);

    // =========================================================
    // counter: any gap in the fault restarts the persistence window
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else if (!raw) begin
            cnt_q <= '0;
        end else if (cnt_q < lim) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            filt_q <= 1'b0;
        end else begin
            filt_q <= raw && (cnt_q >= lim - 1'b1); // RULE_12
        end
    end

    // =========================================================
    // checks
    property p_deb_persist;
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(filt_q) |-> $past(raw) && ($past(cnt_q) >= $past(lim) - 1'b1);
    endproperty
    a_deb_persist: assert property (p_deb_persist) // RULE_12
        else $error("fault recognised before debounce time");

endmodule

`default_nettype wire

// ### dv/frc_plant_model.sv
// power stage model: switching cycle ticks and soft start completion
`timescale 1ns/1ps
`default_nettype none
module frc_plant_model #(
    parameter int SW_PERIOD = 5,
    parameter int SS_FAST = 4,
    parameter int SS_SLOW = 40
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic soft_start_req_q,
    input wire logic slow,
    output logic sw_cycle,
    output logic soft_start_done
);
    int sw_cnt;
    int ss_cnt;
    // ====================
    // switching ticks run free, as the real oscillator does
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            sw_cnt <= 0;
            sw_cycle <= 1'b0;
        end else begin
            sw_cnt <= (sw_cnt == SW_PERIOD - 1) ? 0 : sw_cnt + 1;
            sw_cycle <= (sw_cnt == 0);
        end
    end
    // ====================
    // one done pulse per request; the slow ramp makes the sequencer wait
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ss_cnt <= 0;
            soft_start_done <= 1'b0;
        end else begin
            soft_start_done <= soft_start_req_q &&
                (ss_cnt == (slow ? SS_SLOW : SS_FAST));
            if (!soft_start_req_q) begin
                ss_cnt <= 0;
            end else if (ss_cnt <= SS_SLOW) begin
                ss_cnt <= ss_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/tb.sv
// self-checking bench for the fault response registers and sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    import frc_pkg::*;
    localparam int RSTEP = 10;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    frc_reg_req_t reg_req = '0;
    frc_fault_in_t faults = '0;
    logic power_on_request = 1'b0;
    logic flag_clear = 1'b0;
    logic slow = 1'b0;
    logic sw_cycle, soft_start_done, reg_rvalid_q, pwm_enable_q;
    logic pwm_terminate_q, soft_start_req_q, eeprom_save_q, eeprom_reload_q;
    logic [7:0] reg_rdata_q;
    logic [7:0] rd;
    frc_flag_id_t first_flag_id_q;
    int error_cnt = 0;
    int n_checks = 0;
    int save_cnt = 0;
    int load_cnt = 0;
    int ss_cnt = 0;
    int c, s0, l0;
    logic [15:0] addrs [5] = '{16'hFE00, 16'hFE01, 16'hFE02, 16'hFE03,
        16'hFE04};
    logic [7:0] masks [5] = '{8'hF0, 8'hC0, 8'hC0, 8'h7F, 8'h00};

    always #2 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        save_cnt += (eeprom_save_q === 1'b1);
        load_cnt += (eeprom_reload_q === 1'b1);
        ss_cnt += (soft_start_req_q === 1'b1);
    end

    frc_fault_response #(.RETRY_STEP_CYC(RSTEP), .DEB_LONG_CYC(20)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
        .faults(faults), .sw_cycle(sw_cycle),
        .power_on_request(power_on_request), .flag_clear(flag_clear),
        .soft_start_done(soft_start_done), .pwm_enable_q(pwm_enable_q),
        .pwm_terminate_q(pwm_terminate_q),
        .soft_start_req_q(soft_start_req_q), .eeprom_save_q(eeprom_save_q),
        .eeprom_reload_q(eeprom_reload_q), .first_flag_id_q(first_flag_id_q));
    frc_plant_model i_plant (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow),
        .soft_start_req_q(soft_start_req_q), .sw_cycle(sw_cycle),
        .soft_start_done(soft_start_done));

    // ====================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ====================
    // register port and stimulus
    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask

    task automatic reg_rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        #1;
        chk(reg_rvalid_q, 1'b1);
        d = reg_rdata_q;
    endtask

    // bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_pwm(input logic lvl, input int bound, output int n);
        n = 0;
        while (pwm_enable_q !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > bound) begin
                chk(pwm_enable_q, lvl);
                end_sim();
            end
        end
    endtask

    task automatic hold_pwm(input logic lvl, input int n);
        int bad;
        bad = 0;
        repeat (n) begin
            @(negedge clk_sys);
            bad += (pwm_enable_q !== lvl);
        end
        chk(bad, 0);
    endtask

    // k: 0 overcurrent, 1 fast overvoltage, 2 open loop
    task automatic hit(input int k);
        @(posedge clk_sys);
        faults <= frc_fault_in_t'(4'b1000 >> k);
        @(posedge clk_sys);
        faults <= '0;
        #1;
        chk(pwm_terminate_q, k == 0);
    endtask

    task automatic clear_flag();
        @(posedge clk_sys);
        flag_clear <= 1'b1;
        @(posedge clk_sys);
        flag_clear <= 1'b0;
        @(negedge clk_sys);
        chk(first_flag_id_q, FRC_ID_NONE);
    endtask

    task automatic recover(input int act, input frc_flag_id_t id);
        int n;
        if (act == 0) begin
            hold_pwm(1'b1, 40);
            return;
        end
        wait_pwm(1'b0, 100, n);
        chk(first_flag_id_q, id);
        ss_cnt = 0;
        if (act > 1) begin
            hold_pwm(1'b0, 30);
            @(posedge clk_sys);
            power_on_request <= 1'b1;
        end
        if (act == 3) begin
            hold_pwm(1'b0, 20);
            @(posedge clk_sys);
            power_on_request <= 1'b0;
            clear_flag();
        end
        wait_pwm(1'b1, 100, n);
        @(posedge clk_sys);
        power_on_request <= 1'b0;
        chk(ss_cnt > 0, act != 3);
        clear_flag();
    endtask

    task automatic ocp_run(input int act, input int nf);
        int cnt;
        reg_wr(FRC_ADDR_OCP, 8'((act << 6) | (nf << 4)));
        hit(0);
        cnt = 0;
        for (int i = 0; i < 200 && act != 0 && pwm_enable_q === 1'b1; i++) begin
            @(negedge clk_sys);
            cnt += (pwm_enable_q === 1'b1 && sw_cycle === 1'b1);
        end
        if (act != 0) begin
            chk(cnt, 1 << nf);
        end
        recover(act, FRC_ID_OCP);
    endtask

    // ====================
    // main sequence
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wait_pwm(1'b1, 5, c);
        for (int i = 0; i < 5; i++) begin
            reg_rd(addrs[i], rd);
            chk(rd, 8'h00);
        end
        for (int i = 0; i < 5; i++) begin
            reg_wr(addrs[i], 8'hFF);
            reg_rd(addrs[i], rd);
            chk(rd, masks[i]);
            reg_wr(addrs[i], 8'h00);
        end
        ocp_run(0, 0);
        for (int nf = 0; nf < 4; nf++) begin
            ocp_run(1, nf);
        end
        ocp_run(2, 1);
        ocp_run(3, 2);
        reg_wr(FRC_ADDR_OCP, 8'h00);
        for (int k = 1; k < 3; k++) begin
            for (int a = 0; a < 4; a++) begin
                reg_wr(k == 1 ? FRC_ADDR_OVP : FRC_ADDR_OLP, 8'(a << 6));
                hit(k);
                recover(a, frc_flag_id_t'(k + 1));
            end
        end
        // retry wait of three steps with save and reload, slow soft start
        @(posedge clk_sys);
        slow <= 1'b1;
        reg_wr(FRC_ADDR_VDD, 8'h5C);
        reg_wr(FRC_ADDR_OVP, 8'h40);
        s0 = save_cnt;
        l0 = load_cnt;
        hit(1);
        wait_pwm(1'b0, 100, c);
        for (c = 0; c < 100 && soft_start_req_q !== 1'b1; c++) begin
            @(negedge clk_sys);
        end
        chk(c >= 3 * RSTEP && c <= 3 * RSTEP + 4, 1'b1);
        wait_pwm(1'b1, 100, c);
        chk(save_cnt - s0, 1);
        chk(load_cnt - l0, 1);
        clear_flag();
        @(posedge clk_sys);
        slow <= 1'b0;
        reg_wr(FRC_ADDR_VDD, 8'h00);
        s0 = save_cnt;
        l0 = load_cnt;
        hit(1);
        recover(1, FRC_ID_OVP);
        chk(save_cnt - s0 + load_cnt - l0, 0);
        reg_wr(FRC_ADDR_OVP, 8'h00);
        // supply overvoltage: ignored, then long and short persistence
        reg_wr(FRC_ADDR_VDD, 8'h01);
        faults.vdd_ov <= 1'b1;
        hold_pwm(1'b1, 60);
        @(posedge clk_sys);
        faults.vdd_ov <= 1'b0;
        reg_wr(FRC_ADDR_VDD, 8'h00);
        repeat (30) @(posedge clk_sys);
        faults.vdd_ov <= 1'b1;
        hold_pwm(1'b1, 12);
        wait_pwm(1'b0, 30, c);
        chk(first_flag_id_q, FRC_ID_VDD);
        @(posedge clk_sys);
        faults.vdd_ov <= 1'b0;
        wait_pwm(1'b1, 100, c);
        clear_flag();
        reg_wr(FRC_ADDR_VDD, 8'h02);
        repeat (30) @(posedge clk_sys);
        faults.vdd_ov <= 1'b1;
        hold_pwm(1'b1, 200);
        wait_pwm(1'b0, 600, c);
        @(posedge clk_sys);
        faults.vdd_ov <= 1'b0;
        wait_pwm(1'b1, 100, c);
        end_sim();
    end
endmodule
`default_nettype wire
